/* File: design/pmsc_pkg.sv */
// Constants, types and register map of the power mode and system control block
package pmsc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] PMSC_IDX_SYS1 = 6'h10;
    localparam logic [5:0] PMSC_IDX_SYS2 = 6'h11;
    localparam logic [5:0] PMSC_IDX_RSTAT = 6'h12;
    localparam logic [5:0] PMSC_IDX_PWEN = 6'h13;
    // power_sleep_clock_config fields
    localparam int PMSC_S1_SLEEP = 7;
    localparam int PMSC_S1_PIN_DIS = 6;
    localparam int PMSC_S1_COMBO_DIS = 5;
    localparam int PMSC_S1_XREADY = 4;
    localparam int PMSC_S1_WARM_LSB = 2;
    localparam int PMSC_S1_RANGE = 1;
    localparam int PMSC_S1_RC_ON = 0;
    localparam logic [7:0] PMSC_S1_RESET = 8'h01;
    // clock_source_select fields
    localparam int PMSC_S2_XTAL_ON = 7;
    localparam int PMSC_S2_EXT_FAST = 6;
    localparam int PMSC_S2_FAST_PIN = 5;
    localparam int PMSC_S2_EXT_SLOW = 4;
    localparam int PMSC_S2_SLOW_CPU = 2;
    localparam logic [7:0] PMSC_S2_RESET = 8'h03;
    localparam logic [7:0] PMSC_S2_WMASK = 8'hF7;
    // reset_cause_status fields
    localparam int PMSC_RS_PIN = 7;
    localparam int PMSC_RS_WDOG = 6;
    localparam int PMSC_RS_COMBO = 5;
    localparam int PMSC_RS_UV = 4;
    localparam int PMSC_RS_UNLOCK = 3;
    localparam int PMSC_RS_DEB_ON = 2;
    localparam int PMSC_RS_DEB_CLK = 1;
    localparam int PMSC_RS_LFPIN = 0;
    localparam logic [7:0] PMSC_RS_RESET = 8'h00;
    // power_aux_enable fields: peripheral clock enables low, detectors high
    localparam int PMSC_PW_SUPPLY_LEVEL_DETECTOR = 7;
    localparam int PMSC_PW_UV = 6;
    localparam logic [7:0] PMSC_PW_RESET = 8'h00;
    // Timing
    localparam int PMSC_CLK_HZ = 25_000_000;
    localparam int PMSC_DEB_FAST_HZ = 8192;
    localparam int PMSC_DEB_SLOW_HZ = 256;
    localparam int PMSC_WARM_S = 1;
    localparam int PMSC_DEB_FAST_CYC = PMSC_CLK_HZ / PMSC_DEB_FAST_HZ;
    localparam int PMSC_DEB_SLOW_CYC = PMSC_CLK_HZ / PMSC_DEB_SLOW_HZ;
    localparam int PMSC_WARM_CYC = PMSC_CLK_HZ * PMSC_WARM_S;
    // AXI responses
    localparam logic [1:0] PMSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMSC_RESP_SLVERR = 2'h2;
    // Operating modes
    typedef enum logic [1:0] {PMSC_ACTIVE, PMSC_STANDBY, PMSC_SLEEP} pmsc_mode_t;
endpackage

/* File: design/pmsc_top.sv */
// Operating modes, clock gating, reset causes and clock selection with AXI4-Lite registers
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module pmsc_top
    import pmsc_pkg::*;
#(
    parameter int NPERIPH      = 6,                  // Gated peripheral clocks
    parameter int DEB_SLOW_CYC = PMSC_DEB_SLOW_CYC,  // Slow debounce tick period
    parameter int WARM_CYC     = PMSC_WARM_CYC       // Full crystal warm-up, cycles
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,          // Power-on reset
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               cpu_stop,         // Stop instruction executed
    input  wire logic               irq_req,          // Pending interrupt
    input  wire logic               event_req,        // Pending event
    input  wire logic               porta_wake,       // Port A wake combination
    input  wire logic               porta_combo_rst,  // Port A reset combination
    input  wire logic               watchdog_rst,     // Watchdog timeout
    input  wire logic               undervoltage_rst, // Brown-out detected
    input  wire logic               reset_pin,        // External reset pin, high active
    input  wire logic               lf_pin,           // Slow oscillator output terminal
    input  wire logic               slow_tick,        // Slow domain clock enable
    output logic                    cpu_run,
    output logic                    cpu_reset,
    output logic                    irq_branch,
    output logic                    cpu_clk_tick,
    output logic                    fast_clk_tick,
    output logic [NPERIPH-1:0]      periph_clk_en,
    output logic                    prescaler_run,
    output logic                    debounce_bypass,
    output logic                    supply_level_detector_on,
    output logic                    uv_detect_on,
    output logic                    rc_osc_en,
    output logic                    rc_range_10m,
    output logic                    crystal_en,
    output logic                    ext_fast_sel,
    output logic                    fast_pin_sel,
    output logic                    ext_slow_sel,
    output logic                    cpu_slow_sel,
    output logic                    sys_reset_pulse,
    output logic                    standby_mode,
    output logic                    sleep_mode
);

    // Refuse sizes the counters and the enable register cannot hold
    if (NPERIPH < 1 || NPERIPH > 6) begin : g_chk_np
        $error("NPERIPH must be 1 to 6");
    end
    if (DEB_SLOW_CYC < 1 || DEB_SLOW_CYC >= (1 << 17)) begin : g_chk_deb
        $error("DEB_SLOW_CYC out of range");
    end
    if (WARM_CYC < 4 || WARM_CYC >= (1 << 25)) begin : g_chk_warm
        $error("WARM_CYC out of range");
    end

    localparam logic [16:0] DEB_FAST_LAST = 17'(PMSC_DEB_FAST_CYC - 1);
    localparam logic [16:0] DEB_SLOW_LAST = 17'(DEB_SLOW_CYC - 1);

    // Whole state of the block
    typedef struct packed {
        pmsc_mode_t       mode;
        logic [7:0]       sys1;        // Stored bits of power_sleep_clock_config
        logic [7:0]       sys2;        // clock_source_select
        logic [7:0]       rstat;       // Stored bits of reset_cause_status
        logic [7:0]       pwen;        // power_aux_enable
        logic             xready;      // Crystal warm-up done
        logic [24:0]      warm_cnt;
        logic [2:0]       fdiv_cnt;    // Fast domain divider
        logic [16:0]      deb_cnt;     // Debounce tick divider
        logic [1:0]       deb_smp;     // Last debounce samples
        logic [2:0]       pin_sync;
        logic             pin_lvl;
        logic [2:0]       lf_sync;
        logic             lf_lvl;
        logic             aw_have;
        logic             w_have;
        logic [7:0]       aw_addr;
        logic [7:0]       wbyte;
        logic             wlane;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [7:0]       rbyte;
        logic             cpu_run;
        logic             cpu_reset;
        logic             irq_branch;
        logic             cpu_tick;
        logic             fast_tick;
        logic [NPERIPH-1:0] pclk;
        logic             pre_run;
        logic             bypass;
        logic             supply_level_detector;
        logic             uv;
        logic             sys_rst;
    } pmsc_state_t;

    pmsc_state_t st_reg;
    pmsc_state_t st_next;

    // Address to register index; unmapped words give an all-ones index
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        if (idx >= PMSC_IDX_SYS1 && idx <= PMSC_IDX_PWEN) begin
            return idx;
        end
        return 6'h3F;
    endfunction

    // Warm-up length in cycles for the two-bit code
    function automatic logic [24:0] warm_len(input logic [1:0] code);
        unique case (code)
            2'h0: return 25'(WARM_CYC);
            2'h2: return 25'((WARM_CYC / 4) * 3);
            2'h1: return 25'(WARM_CYC / 2);
            2'h3: return 25'(WARM_CYC / 4);
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        logic       pin_fire;      // Accepted pin reset
        logic       combo_fire;    // Accepted port A reset
        logic       any_rst;       // Any reset source that restarts the system
        logic       deb_tick;
        logic       fast_hit;
        logic       cpu_hit;
        logic       sleeping;
        logic       do_write;
        logic [5:0] widx;
        logic [5:0] ridx;
        logic [7:0] rval;
        pin_fire   = 1'b0;
        combo_fire = 1'b0;
        any_rst    = 1'b0;
        deb_tick   = 1'b0;
        fast_hit   = 1'b0;
        cpu_hit    = 1'b0;
        sleeping   = 1'b0;
        do_write   = 1'b0;
        widx       = 6'h3F;
        ridx       = 6'h3F;
        rval       = 8'h00;
        st_next    = st_reg;
        sleeping   = (st_reg.mode == PMSC_SLEEP);

        // Pin synchronisers; a change counts once stages two and three agree
        st_next.pin_sync = {st_reg.pin_sync[1:0], reset_pin};
        if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
            st_next.pin_lvl = st_reg.pin_sync[2];
        end
        st_next.lf_sync = {st_reg.lf_sync[1:0], lf_pin};
        if (st_reg.lf_sync[1] == st_reg.lf_sync[2]) begin
            st_next.lf_lvl = st_reg.lf_sync[2];
        end

        // Debounce tick at the selected prescaler rate, frozen in sleep
        if (!sleeping) begin
            if (st_reg.deb_cnt >= (st_reg.rstat[PMSC_RS_DEB_CLK] ? DEB_FAST_LAST
                                                                 : DEB_SLOW_LAST)) begin
                st_next.deb_cnt = 17'h00000;
                deb_tick        = 1'b1;
            end else begin
                st_next.deb_cnt = st_reg.deb_cnt + 17'h00001;
            end
        end
        if (deb_tick) begin
            st_next.deb_smp = {st_reg.deb_smp[0], st_reg.pin_lvl};
        end

        // Pin reset: direct, debounced, or direct in sleep since debouncers stop
        if (!st_reg.sys1[PMSC_S1_PIN_DIS]) begin
            if (sleeping || !st_reg.rstat[PMSC_RS_DEB_ON]) begin
                pin_fire = st_reg.pin_lvl;
            end else begin
                pin_fire = deb_tick && st_reg.deb_smp[0] && st_reg.pin_lvl;
            end
        end
        combo_fire = porta_combo_rst && !st_reg.sys1[PMSC_S1_COMBO_DIS];
        any_rst    = pin_fire || combo_fire || watchdog_rst || undervoltage_rst;

        // Fast domain divider: 1, 2, 4 or 8, stopped in sleep
        if (!sleeping) begin
            fast_hit = ((st_reg.fdiv_cnt & ((3'h1 << st_reg.sys2[1:0]) - 3'h1)) == 3'h0);
            st_next.fdiv_cnt = st_reg.fdiv_cnt + 3'h1;
        end
        cpu_hit = st_reg.sys2[PMSC_S2_SLOW_CPU] ? slow_tick : fast_hit;

        // Crystal warm-up counter, restarted whenever the crystal is off
        if (!st_reg.sys2[PMSC_S2_XTAL_ON] || sleeping) begin
            st_next.warm_cnt = 25'h0000000;
            st_next.xready   = 1'b0;
        end else if (!st_reg.xready) begin
            if (st_reg.warm_cnt + 25'h0000001 >= warm_len(st_reg.sys1[3:2])) begin
                st_next.xready = 1'b1;
            end
            st_next.warm_cnt = st_reg.warm_cnt + 25'h0000001;
        end

        // Write channel: address and data taken in either order
        st_next.awready = 1'b0;
        st_next.wready  = 1'b0;
        if (!st_reg.aw_have && s_axi_awvalid && !st_reg.awready) begin
            st_next.awready = 1'b1;
        end
        if (!st_reg.w_have && s_axi_wvalid && !st_reg.wready) begin
            st_next.wready = 1'b1;
        end
        if (st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.wbyte  = s_axi_wdata[7:0];
            st_next.wlane  = s_axi_wstrb[0];
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            widx            = reg_index(st_reg.aw_addr);
            do_write        = (widx != 6'h3F) && st_reg.wlane;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = (widx == 6'h3F) ? PMSC_RESP_SLVERR : PMSC_RESP_OKAY;
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // Register writes
        if (do_write) begin
            unique case (widx)
                PMSC_IDX_SYS1: begin
                    // Sleep bit writable only while unlocked
                    if (st_reg.rstat[PMSC_RS_UNLOCK]) begin
                        st_next.sys1[PMSC_S1_SLEEP] = st_reg.wbyte[PMSC_S1_SLEEP];
                    end
                    st_next.sys1[6:5] = st_reg.wbyte[6:5];
                    st_next.sys1[3:2] = st_reg.wbyte[3:2];
                    st_next.sys1[1:0] = st_reg.wbyte[1:0];
                end
                PMSC_IDX_SYS2: st_next.sys2 = st_reg.wbyte & PMSC_S2_WMASK;
                PMSC_IDX_RSTAT: begin
                    // Flags only clear on a zero; ones leave them alone
                    st_next.rstat[7:4] = st_reg.rstat[7:4] & st_reg.wbyte[7:4];
                    st_next.rstat[3:1] = st_reg.wbyte[3:1];
                end
                PMSC_IDX_PWEN: st_next.pwen = st_reg.wbyte;
                default: ;
            endcase
        end

        // Sticky cause flags; a new cause beats a clear in the same cycle
        if (pin_fire) st_next.rstat[PMSC_RS_PIN] = 1'b1;
        if (watchdog_rst) st_next.rstat[PMSC_RS_WDOG] = 1'b1;
        if (combo_fire || (undervoltage_rst && st_reg.sys1[PMSC_S1_COMBO_DIS])) begin
            st_next.rstat[PMSC_RS_COMBO] = 1'b1;
        end
        if (undervoltage_rst) st_next.rstat[PMSC_RS_UV] = 1'b1;

        // Read channel; one read at a time
        st_next.arready = 1'b0;
        if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
            st_next.arready = 1'b1;
            ridx            = reg_index(s_axi_araddr);
            unique case (ridx)
                PMSC_IDX_SYS1: begin
                    rval = st_reg.sys1;
                    rval[PMSC_S1_XREADY] = st_reg.xready;
                end
                PMSC_IDX_SYS2: rval = st_reg.sys2;
                PMSC_IDX_RSTAT: begin
                    rval = st_reg.rstat;
                    rval[PMSC_RS_LFPIN] = !st_reg.sys2[PMSC_S2_XTAL_ON] && st_reg.lf_lvl;
                end
                PMSC_IDX_PWEN: rval = st_reg.pwen;
                default: rval = 8'h00;
            endcase
            st_next.rvalid = 1'b1;
            st_next.rbyte  = rval;
            st_next.rresp  = (ridx == 6'h3F) ? PMSC_RESP_SLVERR : PMSC_RESP_OKAY;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // Mode sequencing
        unique case (st_reg.mode)
            PMSC_ACTIVE: begin
                if (st_next.sys1[PMSC_S1_SLEEP]) begin
                    st_next.mode = PMSC_SLEEP;
                end else if (cpu_stop) begin
                    st_next.mode = PMSC_STANDBY;
                end
            end
            PMSC_STANDBY: begin
                if ((irq_req || event_req) && cpu_hit) begin
                    st_next.mode = PMSC_ACTIVE;
                end
            end
            PMSC_SLEEP: begin
                // Only the wake combination or a reset ends sleep
                if (porta_wake || any_rst) begin
                    st_next.mode = PMSC_ACTIVE;
                    st_next.sys1[PMSC_S1_SLEEP] = 1'b0;
                end
            end
        endcase

        // System reset: back to active with system and main fields restored
        st_next.sys_rst = any_rst;
        if (any_rst) begin
            st_next.mode = PMSC_ACTIVE;
            st_next.sys1[PMSC_S1_SLEEP] = 1'b0;
            st_next.sys1[1:0] = PMSC_S1_RESET[1:0];
            st_next.rstat[2:1] = PMSC_RS_RESET[2:1];
            st_next.sys2 = PMSC_S2_RESET;
            st_next.xready = 1'b0;
            st_next.warm_cnt = 25'h0000000;
        end

        // Registered outputs derived from the mode now being entered; cpu tick and irq branch use the current mode
        st_next.cpu_run    = (st_next.mode == PMSC_ACTIVE);
        st_next.cpu_reset  = (st_next.mode == PMSC_SLEEP) || any_rst;
        st_next.irq_branch = (st_reg.mode == PMSC_ACTIVE) && irq_req && cpu_hit;
        st_next.cpu_tick   = cpu_hit && (st_reg.mode == PMSC_ACTIVE);
        st_next.fast_tick  = fast_hit;
        if (st_next.mode == PMSC_SLEEP) begin
            st_next.pclk = '0;
        end else begin
            st_next.pclk = st_next.pwen[NPERIPH-1:0];
        end
        st_next.pre_run = (st_next.mode != PMSC_SLEEP);
        st_next.bypass  = (st_next.mode == PMSC_SLEEP);
        st_next.supply_level_detector    = st_next.pwen[PMSC_PW_SUPPLY_LEVEL_DETECTOR] && st_next.mode != PMSC_SLEEP;
        st_next.uv      = st_next.pwen[PMSC_PW_UV] && st_next.mode != PMSC_SLEEP;
    end

    // State register; power-on reset restores everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.mode    <= PMSC_ACTIVE;
            st_reg.sys1    <= PMSC_S1_RESET;
            st_reg.sys2    <= PMSC_S2_RESET;
            st_reg.rstat   <= PMSC_RS_RESET;
            st_reg.pwen    <= PMSC_PW_RESET;
            st_reg.cpu_run <= 1'b1;
            st_reg.pre_run <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Ports straight from the state register
    assign s_axi_awready   = st_reg.awready;
    assign s_axi_wready    = st_reg.wready;
    assign s_axi_bvalid    = st_reg.bvalid;
    assign s_axi_bresp     = st_reg.bresp;
    assign s_axi_arready   = st_reg.arready;
    assign s_axi_rvalid    = st_reg.rvalid;
    assign s_axi_rresp     = st_reg.rresp;
    assign s_axi_rdata     = {24'h000000, st_reg.rbyte};
    assign cpu_run         = st_reg.cpu_run;
    assign cpu_reset       = st_reg.cpu_reset;
    assign irq_branch      = st_reg.irq_branch;
    assign cpu_clk_tick    = st_reg.cpu_tick;
    assign fast_clk_tick   = st_reg.fast_tick;
    assign periph_clk_en   = st_reg.pclk;
    assign prescaler_run   = st_reg.pre_run;
    assign debounce_bypass = st_reg.bypass;
    assign supply_level_detector_on         = st_reg.supply_level_detector;
    assign uv_detect_on    = st_reg.uv;
    // Oscillator enables are forced off while asleep
    assign rc_osc_en       = st_reg.sys1[PMSC_S1_RC_ON] && st_reg.pre_run;
    assign rc_range_10m    = st_reg.sys1[PMSC_S1_RANGE];
    assign crystal_en      = st_reg.sys2[PMSC_S2_XTAL_ON] && st_reg.pre_run;
    assign ext_fast_sel    = st_reg.sys2[PMSC_S2_EXT_FAST];
    assign fast_pin_sel    = st_reg.sys2[PMSC_S2_FAST_PIN];
    assign ext_slow_sel    = st_reg.sys2[PMSC_S2_EXT_SLOW];
    assign cpu_slow_sel    = st_reg.sys2[PMSC_S2_SLOW_CPU];
    assign sys_reset_pulse = st_reg.sys_rst;
    assign standby_mode    = (st_reg.mode == PMSC_STANDBY);
    assign sleep_mode      = (st_reg.mode == PMSC_SLEEP);

endmodule

/* File: dv/pmsc_properties.sv */
// Assertions on modes, clock gating and wake-up of the power mode block
`timescale 1ns/1ns
module pmsc_properties #(parameter int NPERIPH = 6) (
    input wire logic               aclk, aresetn, cpu_stop, irq_req, event_req, porta_wake,
    input wire logic               cpu_run, cpu_reset, prescaler_run, debounce_bypass,
    input wire logic               crystal_en, supply_level_detector_on, uv_detect_on, standby_mode, sleep_mode,
    input wire logic [NPERIPH-1:0] periph_clk_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Settled modes: registered outputs may trail the mode flop by a cycle
    sequence s_slept; sleep_mode && $past(sleep_mode); endsequence
    sequence s_halted; standby_mode && $past(standby_mode); endsequence
    // Wake-up waits for a cpu tick, up to eight cycles at divide by 8
    sequence s_woke; ##[1:12] cpu_run; endsequence
    chk_sleep_gate:
        assert property (s_slept |-> periph_clk_en == '0 && !prescaler_run) else $error("clk in sleep");
    chk_sleep_cpu:
        assert property (s_slept |-> cpu_reset && !cpu_run && !crystal_en) else $error("cpu in sleep");
    chk_sleep_bypass:
        assert property (s_slept |-> debounce_bypass) else $error("debounce in sleep");
    chk_sleep_detect:
        assert property (s_slept |-> !supply_level_detector_on && !uv_detect_on) else $error("detector in sleep");
    chk_stop_entry:
        assert property (cpu_run && cpu_stop && !irq_req && !event_req |-> ##[1:3] standby_mode)
        else $error("no standby");
    chk_standby_hold:
        assert property (s_halted |-> !cpu_run && prescaler_run) else $error("standby wrong");
    chk_standby_wake:
        assert property (standby_mode && (irq_req || event_req) |-> s_woke) else $error("no wake");
    chk_sleep_exit:
        assert property (sleep_mode && porta_wake |-> ##[1:4] !sleep_mode) else $error("no exit");
endmodule
bind pmsc_top pmsc_properties #(.NPERIPH(NPERIPH)) pmsc_properties_inst (.*);

/* File: dv/testbench.sv */
// Self-checking bench for the power mode and system control block
`timescale 1ns/1ns
module testbench;
    import pmsc_pkg::*;
    // Inputs; reset pin, combo reset and slow tick stay idle
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_stop = 1'h0;
    logic irq_req = 1'h0, event_req = 1'h0, porta_wake = 1'h0, porta_combo_rst = 1'h0;
    logic watchdog_rst = 1'h0, undervoltage_rst = 1'h0, reset_pin = 1'h0, lf_pin = 1'h1;
    logic slow_tick = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] periph_clk_en;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_run;
    logic cpu_reset, irq_branch, cpu_clk_tick, fast_clk_tick, prescaler_run, debounce_bypass;
    logic supply_level_detector_on, uv_detect_on, rc_osc_en, rc_range_10m, crystal_en, ext_fast_sel;
    logic fast_pin_sel, ext_slow_sel, cpu_slow_sel, sys_reset_pulse, standby_mode, sleep_mode;
    int miscompares = 0, tests_run = 0;
    // Short debounce and warm-up counts keep the run brief
    pmsc_top #(.DEB_SLOW_CYC(8), .WARM_CYC(40)) pmsc_top_inst (.*);
    always #20 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write: both channels offered together; bready simply stays up afterwards
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h000000, d}; s_axi_bready <= 1'h1;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
    endtask
    // Read and compare; one idle edge so arvalid is not reassigned at once
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
        @(posedge aclk);
    endtask
    task automatic t_regs;
        chk(cpu_run, 32'h1);
        chk(rc_osc_en, 32'h1);
        rd(8'h40, 32'h01);
        rd(8'h44, 32'h03);
        rd(8'h48, 32'h01);
        rd(8'h50, 32'h00, PMSC_RESP_SLVERR);
        wr(8'h44, 8'h8B);
        chk(crystal_en, 32'h1);
        rd(8'h44, 32'h83);
        rd(8'h48, 32'h00);
    endtask
    // Causes stay set over system resets and clear on a zero write
    task automatic t_causes;
        watchdog_rst <= 1'h1; @(posedge aclk); watchdog_rst <= 1'h0;
        @(posedge aclk);
        chk(sys_reset_pulse, 32'h1);
        repeat (7) @(posedge aclk);
        rd(8'h48, 32'h41);
        wr(8'h48, 8'h00);
        wr(8'h40, 8'h21);
        undervoltage_rst <= 1'h1; @(posedge aclk); undervoltage_rst <= 1'h0;
        repeat (8) @(posedge aclk);
        rd(8'h48, 32'h31);
        rd(8'h40, 32'h21);
    endtask
    task automatic t_sleep;
        wr(8'h4C, 8'hC5);
        @(posedge aclk);
        chk(periph_clk_en, 32'h05);
        chk(supply_level_detector_on, 32'h1);
        chk(uv_detect_on, 32'h1);
        wr(8'h40, 8'hA1);
        rd(8'h40, 32'h21);
        wr(8'h48, 8'h08);
        wr(8'h40, 8'hA1);
        repeat (4) @(posedge aclk);
        chk(sleep_mode, 32'h1);
        chk(periph_clk_en, 32'h00);
        porta_wake <= 1'h1; repeat (4) @(posedge aclk); porta_wake <= 1'h0;
        chk(sleep_mode, 32'h0);
    endtask
    // Divide by 8 in active: two ticks and two branches in any 16 cycles
    task automatic t_irq;
        int n_fast;
        int n_cpu;
        int n_irq;
        n_fast = 0;
        n_cpu = 0;
        n_irq = 0;
        irq_req <= 1'h1;
        @(posedge aclk);
        @(posedge aclk);
        repeat (16) begin
            @(posedge aclk);
            n_fast += fast_clk_tick;
            n_cpu += cpu_clk_tick;
            n_irq += irq_branch;
        end
        irq_req <= 1'h0;
        @(posedge aclk);
        chk(n_fast, 32'h2);
        chk(n_cpu, 32'h2);
        chk(n_irq, 32'h2);
    endtask
    // Standby left once by interrupt, once by event
    task automatic t_standby;
        for (int i = 0; i < 2; i++) begin
            cpu_stop <= 1'h1; @(posedge aclk); cpu_stop <= 1'h0;
            repeat (4) @(posedge aclk);
            chk(standby_mode, 32'h1);
            {irq_req, event_req} <= (i == 0) ? 2'h2 : 2'h1;
            repeat (14) @(posedge aclk);
            chk(cpu_run, 32'h1);
            {irq_req, event_req} <= 2'h0; @(posedge aclk);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        t_regs;
        t_causes;
        t_sleep;
        t_irq;
        t_standby;
        report_and_stop;
    end
    // Watchdog: far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        report_and_stop;
    end
endmodule
